// file: uspc_serial_port.sv
/*
  uart serial port control: register file, transmitter, receiver, flags and interrupt.
  assumes the receive line is synchronous to clk_in and one tick is one bit time.
*/
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module uspc_serial_port
  import uspc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic rxd_in,
  output logic txd_out,
  output logic irq_out
);
  // ********************************
  // registers
  // ********************************
  logic mode_sel_hi, mode_sel_lo, addr_filter_on, rx_enable, tx_ninth_bit, rx_ninth_bit;
  logic transmit_done_flag, receive_done_flag, framing_error_flag;
  logic bit7_select, baud_doubler;
  logic [7:0] node_address, node_addr_mask, rx_data, tx_shift, irq_mask;
  logic [2:0] irq_stat;
  logic [15:0] var_div;
  uspc_tick_if tk ();
  uspc_tick_gen u_tick (.clk_in(clk_in), .rst_in(rst_in), .tk(tk));

  function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] a,
                                    input logic [7:0] m);
    addr_hit = (((b ^ a) & m) == 8'h00) || (((b ^ 8'hff) & (a | m)) == 8'h00);
  endfunction : addr_hit

  uspc_mode_t mode;
  assign mode = uspc_mode_t'({mode_sel_hi, mode_sel_lo});
  always_comb begin
    case (mode)
      USPC_MODE_SHIFT: tk.period = {8'h00, USPC_DIV_MODE0};
      USPC_MODE_U9_FIXED: tk.period = {8'h00, baud_doubler ? USPC_DIV_MODE2_DBL : USPC_DIV_MODE2};
      default: tk.period = var_div;
    endcase
  end

  wire wr_ctrl = wr_in && addr_in == USPC_OFF_CTRL;
  wire wr_data = wr_in && addr_in == USPC_OFF_DATA;

  // ********************************
  // transmitter
  // ********************************
  typedef enum logic [3:0] {
    USPC_TX_IDLE = 4'b0001, USPC_TX_START = 4'b0010, USPC_TX_BITS = 4'b0100,
    USPC_TX_STOP = 4'b1000
  } uspc_tx_t;
  uspc_tx_t tx_st;
  logic [3:0] tx_cnt;
  logic tx_set;
  wire nine = mode[1];
  wire [3:0] nbits = nine ? 4'h9 : 4'h8;
  always_ff @(posedge clk_in) begin
    tx_set <= 1'b0;
    if (rst_in) begin
      tx_st <= USPC_TX_IDLE;
      tx_cnt <= 4'h0;
      tx_shift <= 8'h00;
      txd_out <= 1'b1;
    end else begin
      case (tx_st)
        USPC_TX_IDLE: if (wr_data) begin
          tx_shift <= wdata_in;
          tx_cnt <= 4'h0;
          tx_st <= (mode == USPC_MODE_SHIFT) ? USPC_TX_BITS : USPC_TX_START;
        end
        USPC_TX_START: if (tk.tick) begin
          txd_out <= 1'b0;
          tx_st <= USPC_TX_BITS;
        end
        USPC_TX_BITS: if (tk.tick) begin
          txd_out <= (tx_cnt == 4'h8) ? tx_ninth_bit : tx_shift[0];
          tx_shift <= {1'b0, tx_shift[7:1]};
          tx_cnt <= tx_cnt + 4'h1;
          if (tx_cnt + 4'h1 == nbits) begin
            tx_st <= USPC_TX_STOP;
          end
        end
        USPC_TX_STOP: if (tk.tick) begin
          // done at stop or last bit end
          txd_out <= 1'b1;
          tx_set <= 1'b1;
          tx_st <= USPC_TX_IDLE;
        end
        default: tx_st <= USPC_TX_IDLE;
      endcase
    end
  end

  // ********************************
  // receiver
  // ********************************
  // the first tick after the falling edge already lands in data bit 0, so no start state;
  // bits are taken one clock after their edge, which leaves no margin for a skewed sender
  typedef enum logic [2:0] {
    USPC_RX_IDLE = 3'b001, USPC_RX_BITS = 3'b010, USPC_RX_STOP = 3'b100
  } uspc_rx_t;
  uspc_rx_t rx_st;
  logic [3:0] rx_cnt;
  logic [7:0] rx_shift;
  logic rx_b9, rx_set, fe_set, rx9_load, rx9_val, rxd_prev;
  // outside shift mode a start needs a falling edge, so a low stop bit cannot restart the receiver
  wire rx_go = rx_enable && (mode == USPC_MODE_SHIFT || (rxd_prev && !rxd_in));
  assign tk.restart = (rx_st == USPC_RX_IDLE) && (tx_st == USPC_TX_IDLE) && !wr_data
                      && !rx_go;
  always_ff @(posedge clk_in) begin
    rx_set <= 1'b0;
    fe_set <= 1'b0;
    rx9_load <= 1'b0;
    if (rst_in) begin
      rx_st <= USPC_RX_IDLE;
      rxd_prev <= 1'b1;
      rx_cnt <= 4'h0;
      rx_shift <= 8'h00;
      rx_b9 <= 1'b0;
      rx_data <= 8'h00;
      rx9_val <= 1'b0;
    end else begin
      rxd_prev <= rxd_in;
      case (rx_st)
        USPC_RX_IDLE: if (rx_go) begin
          rx_cnt <= 4'h0;
          rx_st <= USPC_RX_BITS;
        end
        USPC_RX_BITS: if (tk.tick) begin
          if (rx_cnt == 4'h8) rx_b9 <= rxd_in;
          else rx_shift <= {rxd_in, rx_shift[7:1]};
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt + 4'h1 == nbits) begin
            if (mode == USPC_MODE_SHIFT) begin
              // mode 0 done at last bit
              rx_data <= {rxd_in, rx_shift[7:1]};
              rx_set <= 1'b1;
              rx_st <= USPC_RX_IDLE;
            end else begin
              rx_st <= USPC_RX_STOP;
            end
          end
        end
        USPC_RX_STOP: if (tk.tick) begin
          rx_st <= USPC_RX_IDLE;
          rx_data <= rx_shift;
          fe_set <= !rxd_in;
          if (nine) begin
            rx_set <= !addr_filter_on || (rx_b9 && addr_hit(rx_shift, node_address, node_addr_mask));
            rx9_load <= 1'b1;
            rx9_val <= rx_b9;
          end else begin
            rx_set <= !addr_filter_on || (rxd_in && addr_hit(rx_shift, node_address, node_addr_mask));
            rx9_load <= !addr_filter_on;
            rx9_val <= rxd_in;
          end
        end
        default: rx_st <= USPC_RX_IDLE;
      endcase
      if (!rx_enable) rx_st <= USPC_RX_IDLE;
    end
  end

  // ********************************
  // control register and flags
  // ********************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {mode_sel_hi, mode_sel_lo, addr_filter_on, rx_enable, tx_ninth_bit} <= 5'h00;
      rx_ninth_bit <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        if (!bit7_select) mode_sel_hi <= wdata_in[USPC_B_TOP];
        mode_sel_lo <= wdata_in[USPC_B_MODE_LO];
        addr_filter_on <= wdata_in[USPC_B_FILTER];
        rx_enable <= wdata_in[USPC_B_RX_EN];
        tx_ninth_bit <= wdata_in[USPC_B_TX9];
        rx_ninth_bit <= wdata_in[USPC_B_RX9];
      end
      if (rx9_load) rx_ninth_bit <= rx9_val;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      transmit_done_flag <= 1'b0;
      receive_done_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      if (wr_ctrl && !wdata_in[USPC_B_TX_DONE]) transmit_done_flag <= 1'b0;
      if (wr_ctrl && !wdata_in[USPC_B_RX_DONE]) receive_done_flag <= 1'b0;
      // clear only through selected top bit
      if (wr_ctrl && bit7_select && !wdata_in[USPC_B_TOP]) framing_error_flag <= 1'b0;
      if (tx_set) transmit_done_flag <= 1'b1;
      if (rx_set) receive_done_flag <= 1'b1;
      if (fe_set) framing_error_flag <= 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {bit7_select, baud_doubler} <= 2'b00;
      node_address <= 8'h00;
      node_addr_mask <= 8'h00;
      var_div <= USPC_VAR_DIV_RESET;
      irq_mask <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == USPC_OFF_AUX) begin
        bit7_select <= wdata_in[USPC_B_AUX_SEL7];
        baud_doubler <= wdata_in[USPC_B_AUX_DBL];
      end
      if (addr_in == USPC_OFF_ADDR) node_address <= wdata_in;
      if (addr_in == USPC_OFF_MASK) node_addr_mask <= wdata_in;
      if (addr_in == USPC_OFF_IRQ_MASK) irq_mask <= wdata_in;
    end
  end

  // ********************************
  // interrupt status and read port
  // ********************************
  wire rd_stat = rd_in && addr_in == USPC_OFF_IRQ_STAT;
  // read clears, but a same-cycle event survives
  always_ff @(posedge clk_in) begin
    if (rst_in) irq_stat <= 3'h0;
    else irq_stat <= (rd_stat ? 3'h0 : irq_stat) | {fe_set, tx_set, rx_set};
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) irq_out <= 1'b0;
    else irq_out <= |(irq_stat & irq_mask[2:0]);
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        USPC_OFF_CTRL: rdata_out <= {bit7_select ? framing_error_flag : mode_sel_hi, mode_sel_lo,
          addr_filter_on, rx_enable, tx_ninth_bit, rx_ninth_bit, transmit_done_flag,
          receive_done_flag};
        USPC_OFF_DATA: rdata_out <= rx_data;
        USPC_OFF_AUX: rdata_out <= {6'h00, baud_doubler, bit7_select};
        USPC_OFF_ADDR: rdata_out <= node_address;
        USPC_OFF_MASK: rdata_out <= node_addr_mask;
        USPC_OFF_IRQ_STAT: rdata_out <= {5'h00, irq_stat};
        USPC_OFF_IRQ_MASK: rdata_out <= irq_mask;
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ********************************
  // checks
  // ********************************
  // error stays without a clear
  chk_fe_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    framing_error_flag && !wr_ctrl |=> framing_error_flag) else $error("fe dropped");
  chk_fe_set: assert property (@(posedge clk_in) disable iff (rst_in)
    fe_set |=> framing_error_flag) else $error("fe not set");
  chk_tx_rise: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(transmit_done_flag) |-> $past(tx_set)) else $error("tx flag without event");
  chk_rx_rise: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(receive_done_flag) |-> $past(rx_set)) else $error("rx flag without event");
  chk_rx_off: assert property (@(posedge clk_in) disable iff (rst_in)
    !rx_enable |=> rx_st == USPC_RX_IDLE) else $error("rx active while off");
  chk_tx_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_set |-> txd_out) else $error("stop not high");
  chk_filter_nine: assert property (@(posedge clk_in) disable iff (rst_in)
    rx_set && nine && addr_filter_on |-> $past(rx_b9)) else $error("filter passed data");
  chk_top_read: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_in && addr_in == USPC_OFF_CTRL && bit7_select && !wr_in
    |=> rdata_out[USPC_B_TOP] == $past(framing_error_flag)) else $error("top bit wrong");
  cov_tx: cover property (@(posedge clk_in) tx_set);
  cov_rx: cover property (@(posedge clk_in) rx_set && addr_filter_on);
  cov_fe: cover property (@(posedge clk_in) fe_set);
endmodule : uspc_serial_port

// file: uspc_pkg.sv
/*
  uart serial port control: package of offsets, field positions, reset values, modes, timing.
  assumes a single 50 MHz clock and the plain strobe register port.
*/
// Operation
// - bad stop bit sets framing error
// - framing error sticky until software write
// - top bit is framing error only when selected
// - framing error ignores baud doubler
// - two mode bits pick four modes
// - 9-bit filter: ninth bit one, address match
// - 8-bit filter: address must match
// - receive only while receive enable set
// - modes 2,3 send software ninth bit
// - ninth bit field: data bit or stop
// - transmit done at last bit or stop
// - receive done at last bit or mid-stop (here one clock into the stop bit)
// - top bit shared: framing error or mode
// - given address is node AND mask
// - broadcast address is node OR mask
// - 8-bit filter also needs valid stop
package uspc_pkg;
  // ********************************
  // register map
  // ********************************
  localparam logic [3:0] USPC_OFF_CTRL = 4'h0;
  localparam logic [3:0] USPC_OFF_DATA = 4'h1;
  localparam logic [3:0] USPC_OFF_AUX = 4'h2;
  localparam logic [3:0] USPC_OFF_ADDR = 4'h3;
  localparam logic [3:0] USPC_OFF_MASK = 4'h4;
  localparam logic [3:0] USPC_OFF_IRQ_STAT = 4'h5;
  localparam logic [3:0] USPC_OFF_IRQ_MASK = 4'h6;
  localparam logic [7:0] USPC_CTRL_RESET = 8'h00;
  // ********************************
  // control fields
  // ********************************
  localparam int USPC_B_TOP = 7;
  localparam int USPC_B_MODE_LO = 6;
  localparam int USPC_B_FILTER = 5;
  localparam int USPC_B_RX_EN = 4;
  localparam int USPC_B_TX9 = 3;
  localparam int USPC_B_RX9 = 2;
  localparam int USPC_B_TX_DONE = 1;
  localparam int USPC_B_RX_DONE = 0;
  localparam int USPC_B_AUX_SEL7 = 0;
  localparam int USPC_B_AUX_DBL = 1;
  // ********************************
  // timing
  // ********************************
  localparam int USPC_CLK_HZ = 50000000;
  localparam logic [7:0] USPC_DIV_MODE0 = 8'h0c;
  localparam logic [7:0] USPC_DIV_MODE2 = 8'h40;
  localparam logic [7:0] USPC_DIV_MODE2_DBL = 8'h20;
  localparam logic [15:0] USPC_VAR_DIV_RESET = 16'h01b2;
  typedef enum logic [1:0] {
    USPC_MODE_SHIFT = 2'b00,
    USPC_MODE_U8 = 2'b01,
    USPC_MODE_U9_FIXED = 2'b10,
    USPC_MODE_U9_VAR = 2'b11
  } uspc_mode_t;
endpackage : uspc_pkg

// file: uspc_tick_if.sv
/*
  uart serial port control: interface carrying the bit-rate tick to the core.
  assumes one clock domain.
*/
`timescale 1ns/100ps
interface uspc_tick_if;
  logic [15:0] period;
  logic tick;
  logic restart;
  modport gen (input period, input restart, output tick);
  modport core (output period, output restart, input tick);
endinterface : uspc_tick_if

// file: uspc_tick_gen.sv
/*
  uart serial port control: bit-rate divider giving a one-cycle enable.
  assumes period of at least one and a synchronous high reset.
*/
`timescale 1ns/100ps
module uspc_tick_gen
  import uspc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  uspc_tick_if.gen tk
);
  logic [15:0] count;
  always_ff @(posedge clk_in) begin
    if (rst_in || tk.restart) begin
      count <= 16'h0000;
      tk.tick <= 1'b0;
    end else if (count + 16'h0001 >= tk.period) begin
      count <= 16'h0000;
      tk.tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tk.tick <= 1'b0;
    end
  end
endmodule : uspc_tick_gen

// file: uspc_uart_node.sv
/*
  far-side uart node model: sends frames to the port and captures its frames.
  assumes the block clock and bit periods given as whole clock counts.
*/
`timescale 1ns/100ps
module uspc_uart_node (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  // ********************************
  // sender
  // ********************************
  initial rxd_out = 1'b1;
  task automatic send(input int per, input logic nine, input logic [7:0] d,
                      input logic b9, input logic stp);
    logic [10:0] bits;
    int n;
    bits = {stp, b9, d, 1'b0};
    n = nine ? 11 : 10;
    if (!nine) begin
      bits[9] = stp;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      rxd_out <= bits[i];
      repeat (per - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
    rxd_out <= 1'b1;
    // idle gap holds the line high for two bit periods before the next frame
    repeat (2 * per) @(posedge clk_in);
  endtask : send
  // ********************************
  // capture, mid-bit sampling
  // ********************************
  task automatic take(input int per, input logic nine, output logic [7:0] d,
                      output logic b9, output logic stp, output logic ok);
    logic [10:0] bits;
    int n;
    n = nine ? 11 : 10;
    bits = 11'h000;
    ok = 1'b0;
    for (int w = 0; w < 4 * per && !ok; w++) begin
      @(posedge clk_in);
      ok = !txd_in;
    end
    repeat (per / 2) @(posedge clk_in);
    ok = ok & !txd_in;
    for (int i = 1; i < n; i++) begin
      repeat (per) @(posedge clk_in);
      bits[i] = txd_in;
    end
    d = bits[8:1];
    b9 = bits[9];
    stp = nine ? bits[10] : bits[9];
  endtask : take
endmodule : uspc_uart_node

// file: uspc_serial_port_tb.sv
/*
  self-checking bench of the serial port: register tasks and one task per scenario.
  assumes the uart node model on the serial pins and the package offsets.
*/
`timescale 1ns/100ps
module uspc_serial_port_tb
  import uspc_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic rxd_in;
  logic txd_out;
  logic irq_out;
  int err_total = 0;
  int cmp_count = 0;
  always #10 clk_in = ~clk_in;
  uspc_serial_port i_uspc_serial_port (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .rxd_in(rxd_in), .txd_out(txd_out), .irq_out(irq_out));
  uspc_uart_node i_uspc_uart_node (.clk_in(clk_in), .txd_in(txd_out), .rxd_out(rxd_in));
  // ********************************
  // shared tasks
  // ********************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(rdata_out & m, exp);
  endtask : rdchk
  task automatic filt(input logic [7:0] ctl, input int per, input logic nine,
                      input logic [7:0] d, input logic b9, input logic stp,
                      input logic [7:0] exp);
    wr(USPC_OFF_CTRL, ctl);
    i_uspc_uart_node.send(per, nine, d, b9, stp);
    rdchk(USPC_OFF_CTRL, 8'h01, exp);
  endtask : filt
  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset();
    rdchk(USPC_OFF_CTRL, 8'hff, USPC_CTRL_RESET);
    rdchk(4'hf, 8'hff, 8'h00);
    chk({7'h00, irq_out}, 8'h00);
  endtask : t_reset
  // shift mode: eight bits of twelve clocks, no start or stop
  task automatic t_shift();
    wr(USPC_OFF_CTRL, 8'h00);
    wr(USPC_OFF_DATA, 8'hbf);
    repeat (90) @(posedge clk_in);
    chk({7'h00, txd_out}, 8'h00);
    rdchk(USPC_OFF_CTRL, 8'h02, 8'h00);
    repeat (20) @(posedge clk_in);
    rdchk(USPC_OFF_CTRL, 8'h02, 8'h02);
  endtask : t_shift
  task automatic t_tx();
    logic [7:0] d;
    logic b9;
    logic stp;
    logic ok;
    wr(USPC_OFF_CTRL, 8'h88);
    wr(USPC_OFF_DATA, 8'ha5);
    i_uspc_uart_node.take(64, 1'b1, d, b9, stp, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, 8'ha5);
    chk({6'h00, b9, stp}, 8'h03);
    rdchk(USPC_OFF_CTRL, 8'hff, 8'h8a);
    wr(USPC_OFF_CTRL, 8'h88);
    rdchk(USPC_OFF_CTRL, 8'hff, 8'h88);
  endtask : t_tx
  task automatic t_rx();
    wr(USPC_OFF_IRQ_MASK, 8'h01);
    wr(USPC_OFF_CTRL, 8'h90);
    i_uspc_uart_node.send(64, 1'b1, 8'h3c, 1'b1, 1'b1);
    rdchk(USPC_OFF_DATA, 8'hff, 8'h3c);
    rdchk(USPC_OFF_CTRL, 8'hff, 8'h95);
    chk({7'h00, irq_out}, 8'h01);
    rdchk(USPC_OFF_IRQ_STAT, 8'h01, 8'h01);
    repeat (2) @(posedge clk_in);
    chk({7'h00, irq_out}, 8'h00);
    wr(USPC_OFF_IRQ_MASK, 8'h00);
  endtask : t_rx
  // top bit toggles between error flag and mode bit by the select
  task automatic t_fe();
    wr(USPC_OFF_AUX, 8'h03);
    wr(USPC_OFF_CTRL, 8'h90);
    rdchk(USPC_OFF_CTRL, 8'h80, 8'h00);
    i_uspc_uart_node.send(32, 1'b1, 8'h55, 1'b1, 1'b0);
    rdchk(USPC_OFF_CTRL, 8'h80, 8'h80);
    i_uspc_uart_node.send(32, 1'b1, 8'h55, 1'b1, 1'b1);
    rdchk(USPC_OFF_CTRL, 8'h80, 8'h80);
    wr(USPC_OFF_CTRL, 8'h10);
    rdchk(USPC_OFF_CTRL, 8'h80, 8'h00);
    wr(USPC_OFF_AUX, 8'h00);
    rdchk(USPC_OFF_CTRL, 8'h80, 8'h80);
  endtask : t_fe
  // given c0 and fd gives 1100 00x0, broadcast fd
  task automatic t_filter();
    int vp;
    vp = int'(USPC_VAR_DIV_RESET);
    wr(USPC_OFF_ADDR, 8'hc0);
    wr(USPC_OFF_MASK, 8'hfd);
    filt(8'hb0, 64, 1'b1, 8'hc2, 1'b1, 1'b1, 8'h01);
    filt(8'hb0, 64, 1'b1, 8'hc1, 1'b1, 1'b1, 8'h00);
    filt(8'hb0, 64, 1'b1, 8'hc0, 1'b0, 1'b1, 8'h00);
    filt(8'hb0, 64, 1'b1, 8'hff, 1'b1, 1'b1, 8'h01);
    filt(8'h80, 64, 1'b1, 8'h3c, 1'b0, 1'b1, 8'h00);
    filt(8'h70, vp, 1'b0, 8'h12, 1'b0, 1'b1, 8'h00);
    filt(8'h70, vp, 1'b0, 8'hc2, 1'b0, 1'b0, 8'h00);
    filt(8'h70, vp, 1'b0, 8'hc2, 1'b0, 1'b1, 8'h01);
    filt(8'hf0, vp, 1'b1, 8'hc2, 1'b1, 1'b1, 8'h01);
  endtask : t_filter
  // ********************************
  // sequence and hang guard
  // ********************************
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_shift();
    t_tx();
    t_rx();
    t_fe();
    t_filter();
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk_in);
    err_total++;
    final_report();
  end
endmodule : uspc_serial_port_tb
